//--- design/fbwp_guard.sv
// fbwp_guard: erase/write guard for program memory in 4 kB regions
// assumes flash requests are single-cycle pulses from the controller
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module fbwp_guard #(
   parameter int REGIONS = fbwp_pkg::REGIONS_DEFAULT,
   parameter int ADDR_W = fbwp_pkg::ADDR_W_DEFAULT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic debug_attached,
   input wire logic req_valid,
   input wire logic req_erase,
   input wire logic req_full_chip_erase,
   input wire logic [ADDR_W-1:0] req_addr,
   output logic req_grant,
   output logic hard_fault,
   output logic irq
);
   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (REGIONS <= fbwp_pkg::REGIONS_LOW || REGIONS > 64) begin : g_bad_reg
      $error("REGIONS must be 33..64");
   end
   if (ADDR_W < fbwp_pkg::REGION_SHIFT + 6) begin : g_bad_aw
      $error("ADDR_W too small");
   end

   // ------------------------------------------------------------
   // bus address phase capture
   // ------------------------------------------------------------
   logic wr_pend_q, wr_pend_d;
   logic [11:0] wr_addr_q, wr_addr_d;
   logic [31:0] rdata_q, rdata_d;
   logic [63:0] guard_q, guard_d;
   logic bypass_q, bypass_d;
   logic [fbwp_pkg::EVT_W-1:0] stat_q, stat_d, en_q, en_d;
   logic fault_q, fault_d;
   logic addr_ok;
   logic [11:0] a_off;
   logic [63:0] guard_mask;

   assign addr_ok = hsel && hready && htrans[1];
   assign a_off = haddr[11:0];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   // limits the guard to the regions that really exist
   for (genvar i = 0; i < 64; i++) begin : g_mask
      assign guard_mask[i] = (i < REGIONS);
   end

   // ------------------------------------------------------------
   // flash request check
   // ------------------------------------------------------------
   logic [5:0] region;
   logic in_range, bypass_now, any_guard, region_hit, full_hit;
   logic [fbwp_pkg::EVT_W-1:0] evt;

   assign region = req_addr[fbwp_pkg::REGION_SHIFT +: 6];
   assign in_range = (ADDR_W == fbwp_pkg::REGION_SHIFT + 6) ||
      (req_addr >> (fbwp_pkg::REGION_SHIFT + 6)) == '0;
   assign bypass_now = debug_attached && bypass_q;
   assign any_guard = |guard_q;
   assign region_hit = req_valid && !req_full_chip_erase && in_range &&
      guard_q[region] && !bypass_now;
   assign full_hit = req_valid && req_full_chip_erase && any_guard &&
      !bypass_now;
   // suppression is combinational so the flash never starts the operation
   assign req_grant = req_valid && !region_hit && !full_hit;
   assign hard_fault = fault_q;

   always_comb begin
      evt = '0;
      evt[fbwp_pkg::EVT_REGION] = region_hit;
      evt[fbwp_pkg::EVT_FULL] = full_hit;
   end

   // ------------------------------------------------------------
   // register next state
   // ------------------------------------------------------------
   always_comb begin
      wr_pend_d = addr_ok && hwrite;
      wr_addr_d = addr_ok ? a_off : wr_addr_q;
      rdata_d = rdata_q;
      guard_d = guard_q;
      bypass_d = bypass_q;
      en_d = en_q;
      fault_d = region_hit || full_hit;
      stat_d = stat_q;
      if (wr_pend_q) begin
         case (wr_addr_q)
            fbwp_pkg::OFF_GUARD_LOW: begin
               guard_d[31:0] = guard_q[31:0] | hwdata;
            end
            fbwp_pkg::OFF_GUARD_HIGH: begin
               guard_d[63:32] = guard_q[63:32] | hwdata;
            end
            fbwp_pkg::OFF_DBG_BYPASS: begin
               bypass_d = hwdata[0];
            end
            fbwp_pkg::OFF_IRQ_CLEAR: begin
               stat_d = stat_q & ~hwdata[fbwp_pkg::EVT_W-1:0];
            end
            fbwp_pkg::OFF_IRQ_ENABLE: begin
               en_d = hwdata[fbwp_pkg::EVT_W-1:0];
            end
            default: begin
            end
         endcase
      end
      guard_d = guard_d & guard_mask;
      // a new event wins over a clear in the same cycle
      stat_d = stat_d | evt;
      if (addr_ok && !hwrite) begin
         case (a_off)
            fbwp_pkg::OFF_GUARD_LOW: rdata_d = guard_q[31:0];
            fbwp_pkg::OFF_GUARD_HIGH: rdata_d = guard_q[63:32];
            fbwp_pkg::OFF_DBG_BYPASS: rdata_d = {31'h0, bypass_q};
            fbwp_pkg::OFF_IRQ_STATUS: rdata_d = {30'h0, stat_q};
            fbwp_pkg::OFF_IRQ_ENABLE: rdata_d = {30'h0, en_q};
            default: rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
         rdata_q <= 32'h0000_0000;
         guard_q <= {fbwp_pkg::GUARD_RESET, fbwp_pkg::GUARD_RESET};
         bypass_q <= fbwp_pkg::BYPASS_RESET;
         stat_q <= '0;
         en_q <= '0;
         fault_q <= 1'b0;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rdata_q <= rdata_d;
         guard_q <= guard_d;
         bypass_q <= bypass_d;
         stat_q <= stat_d;
         en_q <= en_d;
         fault_q <= fault_d;
      end
   end

   assign irq = |(stat_q & en_q);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   guard_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(guard_q) != '0 |-> (guard_q & $past(guard_q)) == $past(guard_q))
      else $error("guard bit cleared without reset");
   region_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
      req_valid && !req_full_chip_erase && in_range && guard_q[region] &&
      !(debug_attached && bypass_q) |-> !req_grant ##1 hard_fault)
      else $error("guarded region not blocked");
   full_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
      req_valid && req_full_chip_erase && (|guard_q) && !debug_attached
      |-> !req_grant ##1 hard_fault)
      else $error("full erase not refused");
   free_pass_a: assert property (@(posedge hclk) disable iff (!hresetn)
      req_valid && !req_full_chip_erase && !guard_q[region] |-> req_grant)
      else $error("unguarded request refused");
   debug_skip_a: assert property (@(posedge hclk) disable iff (!hresetn)
      req_valid && debug_attached && bypass_q |-> req_grant ##1 !hard_fault)
      else $error("debug bypass ignored");
   set_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && wr_addr_q == fbwp_pkg::OFF_GUARD_LOW |=>
      (guard_q[31:0] & $past(hwdata)) == $past(hwdata))
      else $error("write one did not set guard");
   high_unused_a: assert property (@(posedge hclk) disable iff (!hresetn)
      guard_q[63:REGIONS] == '0)
      else $error("unused guard bits set");
   bypass_eff_a: assert property (@(posedge hclk) disable iff (!hresetn)
      req_valid && !debug_attached && !req_full_chip_erase && in_range &&
      guard_q[region] |-> !req_grant)
      else $error("bypass acted outside debug");
   region_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
      region == 6'(req_addr >> fbwp_pkg::REGION_SHIFT))
      else $error("region map wrong");

   // ------------------------------------------------------------
   // request and fault assertions
   // ------------------------------------------------------------
   // helper copies of the write data so $past sees a plain signal
   logic [fbwp_pkg::EVT_W-1:0] hw_evt;
   logic hw_bit;
   assign hw_evt = hwdata[fbwp_pkg::EVT_W-1:0];
   assign hw_bit = hwdata[0];

   fault_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hard_fault |-> stat_q != '0)
      else $error("fault without status");

   region_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
      region_hit |=> stat_q[fbwp_pkg::EVT_REGION])
      else $error("region event lost");

   full_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
      full_hit |=> stat_q[fbwp_pkg::EVT_FULL])
      else $error("full erase event lost");

   fault_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !(region_hit || full_hit) |=> !hard_fault)
      else $error("fault without cause");

   grant_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !req_valid |-> !req_grant)
      else $error("grant without request");

   debug_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
      req_valid && debug_attached && !bypass_q && !req_full_chip_erase &&
      in_range && guard_q[region] |-> !req_grant ##1 hard_fault)
      else $error("guard lost in debug");

   debug_full_a: assert property (@(posedge hclk) disable iff (!hresetn)
      req_valid && debug_attached && !bypass_q && req_full_chip_erase &&
      any_guard |-> !req_grant ##1 hard_fault)
      else $error("full erase passed in debug");

   full_free_a: assert property (@(posedge hclk) disable iff (!hresetn)
      req_valid && req_full_chip_erase && !any_guard |-> req_grant)
      else $error("full erase refused unguarded");

   range_free_a: assert property (@(posedge hclk) disable iff (!hresetn)
      req_valid && !req_full_chip_erase && !in_range |-> req_grant)
      else $error("unguarded range refused");

   // ------------------------------------------------------------
   // register assertions
   // ------------------------------------------------------------
   // guard words only move on a bus write, never on their own
   no_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !wr_pend_q |=> guard_q == $past(guard_q))
      else $error("guard changed without write");

   high_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && wr_addr_q == fbwp_pkg::OFF_GUARD_HIGH |=>
      (guard_q & ({$past(hwdata), 32'h0} & guard_mask)) ==
      ({$past(hwdata), 32'h0} & guard_mask))
      else $error("high write did not set guard");

   bypass_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && wr_addr_q == fbwp_pkg::OFF_DBG_BYPASS |=>
      bypass_q == $past(hw_bit))
      else $error("bypass write lost");

   low_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_ok && !hwrite && a_off == fbwp_pkg::OFF_GUARD_LOW |=>
      hrdata == 32'($past(guard_q)))
      else $error("low guard read wrong");

   high_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_ok && !hwrite && a_off == fbwp_pkg::OFF_GUARD_HIGH |=>
      hrdata == 32'($past(guard_q) >> 32))
      else $error("high guard read wrong");

   bypass_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_ok && !hwrite && a_off == fbwp_pkg::OFF_DBG_BYPASS |=>
      hrdata == {31'h0, $past(bypass_q)})
      else $error("bypass read wrong");

   spare_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_ok && !hwrite && a_off == fbwp_pkg::OFF_RESERVED |=>
      hrdata == 32'h0)
      else $error("reserved word not zero");

   bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("bus answer not okay");

   // ------------------------------------------------------------
   // interrupt assertions
   // ------------------------------------------------------------
   // a clear with no event beside it must empty the named bits
   status_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && wr_addr_q == fbwp_pkg::OFF_IRQ_CLEAR && evt == '0 |=>
      (stat_q & $past(hw_evt)) == '0)
      else $error("status clear lost");

   set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
      evt != '0 |=> (stat_q & $past(evt)) == $past(evt))
      else $error("event lost to clear");

   enable_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && wr_addr_q == fbwp_pkg::OFF_IRQ_ENABLE |=>
      en_q == $past(hw_evt))
      else $error("enable write lost");

   irq_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      en_q == '0 |-> !irq)
      else $error("irq while disabled");

   irq_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (stat_q & en_q) != '0 |-> irq)
      else $error("irq missing");
endmodule

//--- design/fbwp_pkg.sv
// fbwp_pkg: constants for the flash region guard
// assumes an ahb-lite register bus with 32-bit data
package fbwp_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] OFF_GUARD_LOW = 12'h600;
   localparam logic [11:0] OFF_GUARD_HIGH = 12'h604;
   localparam logic [11:0] OFF_DBG_BYPASS = 12'h608;
   localparam logic [11:0] OFF_RESERVED = 12'h60c;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h700;
   localparam logic [11:0] OFF_IRQ_CLEAR = 12'h704;
   localparam logic [11:0] OFF_IRQ_ENABLE = 12'h708;
   // ------------------------------------------------------------
   // reset values and layout
   // ------------------------------------------------------------
   localparam logic [31:0] GUARD_RESET = 32'h0000_0000;
   localparam logic BYPASS_RESET = 1'b1;
   localparam int REGION_SHIFT = 12;
   localparam int REGIONS_LOW = 32;
   localparam int REGIONS_DEFAULT = 48;
   localparam int ADDR_W_DEFAULT = 24;
   localparam int EVT_W = 2;
   localparam int EVT_REGION = 0;
   localparam int EVT_FULL = 1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

//--- tb/fbwp_flash_model.sv
// fbwp_flash_model: flash controller side, issues erase/write requests
// assumes the bench calls issue() from one process at a time
`timescale 1ns/100ps
module fbwp_flash_model (
   input wire logic hclk,
   output logic req_valid,
   output logic req_erase,
   output logic req_full_chip_erase,
   output logic [23:0] req_addr
);
   initial begin
      req_valid = 1'b0;
      req_erase = 1'b0;
      req_full_chip_erase = 1'b0;
      req_addr = 24'h000000;
   end
   // one-cycle pulse; address inverted after so stale values never match
   task automatic issue(input logic [23:0] a, input logic f);
      @(posedge hclk);
      req_valid <= 1'b1;
      req_erase <= a[0];
      req_full_chip_erase <= f;
      req_addr <= a;
      @(posedge hclk);
      req_valid <= 1'b0;
      req_full_chip_erase <= 1'b0;
      req_addr <= ~a;
   endtask
endmodule

//--- tb/testbench.sv
// testbench: bus reads/writes and flash requests against fbwp_guard
// assumes one ahb-lite master and the flash model as the only requester
`timescale 1ns/100ps
module testbench;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dbg = 0, rd_ph = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r, r2;
   logic [1:0] htrans = 0;
   logic hreadyout, hresp, vld, ers, full, gnt, hf, irq, f_exp = 0;
   logic [23:0] ra;
   logic [31:0] exp_q[$];
   logic g_q[$];
   integer err_count = 0, cmp_count = 0, cyc = 0, seed = 32'h102472b6;
   fbwp_guard fbwp_guard_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .debug_attached(dbg),
      .req_valid(vld), .req_erase(ers), .req_full_chip_erase(full),
      .req_addr(ra), .req_grant(gnt), .hard_fault(hf), .irq(irq));
   fbwp_flash_model fbwp_flash_model_i (.hclk(hclk), .req_valid(vld),
      .req_erase(ers), .req_full_chip_erase(full), .req_addr(ra));
   initial forever #50 hclk = ~hclk;
   // ------------------------------------------------------------
   // compare and report
   // ------------------------------------------------------------
   task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_rd({31'h0, g}, {31'h0, e});
   endtask
   task automatic test_done;
      $display("compares %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         test_done;
      end
      if (rd_ph && hreadyout === 1'b1)
         chk_rd(hrdata, exp_q.pop_front());
      if (!hresetn)
         f_exp = 1'b0;
      else begin
         chk_bit(hf, f_exp);
         f_exp = 1'b0;
         if (vld) begin
            f_exp = !g_q[0];
            chk_bit(gnt, g_q.pop_front());
         end
      end
   end
   // ------------------------------------------------------------
   // drivers
   // ------------------------------------------------------------
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= fbwp_pkg::HTRANS_NONSEQ;
      haddr <= {20'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph <= !w;
      if (!w) exp_q.push_back(d);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_ph <= 1'b0;
   endtask
   task automatic req(input logic [23:0] a, input logic f, input logic e);
      g_q.push_back(e);
      fbwp_flash_model_i.issue(a, f);
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(0, fbwp_pkg::OFF_GUARD_LOW, 32'h0);
      bus(0, fbwp_pkg::OFF_GUARD_HIGH, 32'h0);
      bus(0, fbwp_pkg::OFF_DBG_BYPASS, 32'h1);
      bus(0, fbwp_pkg::OFF_RESERVED, 32'h0);
      bus(0, 12'h7fc, 32'h0);
      bus(1, fbwp_pkg::OFF_IRQ_ENABLE, 32'h3);
      r = $random(seed);
      bus(1, fbwp_pkg::OFF_GUARD_LOW, r);
      bus(1, fbwp_pkg::OFF_GUARD_LOW, 32'h0);
      bus(0, fbwp_pkg::OFF_GUARD_LOW, r);
      bus(1, fbwp_pkg::OFF_GUARD_HIGH, 32'hffffffff);
      bus(0, fbwp_pkg::OFF_GUARD_HIGH, 32'h0000ffff);
      for (int i = 0; i < 8; i++) begin
         r2 = $random(seed);
         req({7'h0, r2[4:0], r2[27:16]}, 1'b0, !r[r2[4:0]]);
      end
      req(24'h02ffff, 1'b0, 1'b0);
      req(24'h030000, 1'b0, 1'b1);
      req(24'h000000, 1'b1, 1'b0);
      bus(0, fbwp_pkg::OFF_IRQ_STATUS, 32'h3);
      chk_bit(irq, 1'b1);
      bus(1, fbwp_pkg::OFF_IRQ_CLEAR, 32'h3);
      bus(0, fbwp_pkg::OFF_IRQ_STATUS, 32'h0);
      chk_bit(irq, 1'b0);
      dbg <= 1'b1;
      req(24'h000000, 1'b1, 1'b1);
      bus(1, fbwp_pkg::OFF_DBG_BYPASS, 32'h0);
      req(24'h02f000, 1'b0, 1'b0);
      dbg <= 1'b0;
      bus(1, fbwp_pkg::OFF_DBG_BYPASS, 32'h1);
      req(24'h02f000, 1'b0, 1'b0);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(0, fbwp_pkg::OFF_GUARD_HIGH, 32'h0);
      req(24'h02f000, 1'b0, 1'b1);
      repeat (2) @(posedge hclk);
      test_done;
   end
endmodule
